// *** cstg_cfg.svh ***
`ifndef CSTG_CFG_SVH
`define CSTG_CFG_SVH
// Status code reported in the error state.
`define CSTG_ERR_CODE 16'hAA01
`define CSTG_OK_CODE 16'h0000
`define CSTG_CRC_W 16
`define CSTG_RND_W 32
// Failure vector bit positions.
`define CSTG_F_CRC 0
`define CSTG_F_ECB 1
`define CSTG_F_OFB 2
`define CSTG_F_CMAC 3
`define CSTG_F_SHA 4
`define CSTG_NTEST 5
`define CSTG_FAIL_RST 5'h00
`endif

// *** cstg_pkg.sv ***
`include "cstg_cfg.svh"
package cstg_pkg;
	typedef logic [`CSTG_NTEST-1:0] cstg_fail_t;
	typedef enum logic [2:0]
	{
		CSTG_BOOT = 3'h0,
		CSTG_ZERO = 3'h1,
		CSTG_TEST = 3'h2,
		CSTG_RUN = 3'h3,
		CSTG_ERR = 3'h4
	} cstg_state_e;
endpackage : cstg_pkg

// *** cstg_guard.sv ***
`timescale 1ns/1ps
`include "cstg_cfg.svh"
//
// Contract
// (R1) Power-up self-test suite starts automatically after every reset.
// (R2) No crypto service until all known-answer tests passed.
// (R3) Any KAT failure enters error state, code AA01 plus failure bit field.
// (R4) In error state only status report is accepted; others rejected.
// (R5) 16-bit CRC over code image compared to stored reference.
// (R6) AES ECB and OFB encrypt and decrypt KATs with 256-bit key.
// (R7) CMAC KAT with 256-bit key and SHA-256 KAT in suite.
// (R8) Firmware image accepted only if CMAC verification passes.
// (R9) Repeated consecutive LFSR random outputs are rejected.
// (R10) Removal while powered erases traffic and integrity keys immediately; code ignores it while in the boot state, reset included.
// (R11) Removal while unpowered detected at boot erases those keys.
// (R12) Block crypto in error; suppress data out in test, zeroize, error.
// (R13) Keys never appear on any output, status included.
// (R14) Radio identifier mismatch erases AES traffic and rekeying keys.
// (R15) Tamper erases all keys if retention flag set, else RAM keys only; code never erases rekey keys on removal detected at boot.
// (R16) Failure vector one bit per test, cleared at reset, set on failure.
// (R17) Error state held until reset; no service clears it.
module cstg_guard
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_static_tamper,
	input wire logic i_active_tamper,
	input wire logic i_radio_id_mismatch,
	input wire logic i_key_retention,
	input wire logic [`CSTG_CRC_W-1:0] i_crc_calc,
	input wire logic [`CSTG_CRC_W-1:0] i_crc_ref,
	input wire logic i_crc_done,
	input wire logic i_ecb_enc_done,
	input wire logic i_ecb_enc_pass,
	input wire logic i_ecb_dec_done,
	input wire logic i_ecb_dec_pass,
	input wire logic i_ofb_enc_done,
	input wire logic i_ofb_enc_pass,
	input wire logic i_ofb_dec_done,
	input wire logic i_ofb_dec_pass,
	input wire logic i_cmac_done,
	input wire logic i_cmac_pass,
	input wire logic i_sha_done,
	input wire logic i_sha_pass,
	input wire logic i_fw_load_done,
	input wire logic i_fw_cmac_pass,
	input wire logic i_rnd_valid,
	input wire logic [`CSTG_RND_W-1:0] i_rnd_value,
	input wire logic i_req_valid,
	input wire logic i_req_is_status,
	input wire logic i_zero_done,
	output logic o_selftest_start,
	output logic o_crypto_enable,
	output logic o_data_out_enable,
	output logic o_req_accept,
	output logic o_req_reject,
	output logic [`CSTG_CRC_W-1:0] o_status_code,
	output cstg_pkg::cstg_fail_t o_fail_vector,
	output logic o_error,
	output logic o_zero_traffic_keys,
	output logic o_zero_integrity_keys,
	output logic o_zero_rekey_keys,
	output logic o_zero_ram_keys,
	output logic o_fw_accept,
	output logic o_fw_reject,
	output logic o_rnd_valid,
	output logic [`CSTG_RND_W-1:0] o_rnd_value,
	output logic o_rnd_reject
);
	import cstg_pkg::*;

	// ----------------------------------------
	// Self-test sequencing state
	// ----------------------------------------
	cstg_state_e state_q, state_d;
	cstg_fail_t fail_q, fail_d;
	cstg_fail_t seen_q, seen_d;
	logic start_q, start_d;
	logic [3:0] aes_seen_q, aes_seen_d;
	logic [3:0] aes_fail_q, aes_fail_d;

	function automatic logic kat_bad(input logic done, input logic pass);
		kat_bad = done & ~pass;
	endfunction : kat_bad

	always_comb
	begin
		state_d = state_q;
		fail_d = fail_q;
		seen_d = seen_q;
		start_d = 1'b0;
		aes_seen_d = aes_seen_q;
		aes_fail_d = aes_fail_q;
		case (state_q)
			CSTG_BOOT:
			begin
				if (i_static_tamper)
					state_d = CSTG_ZERO; // R11
				else
				begin
					state_d = CSTG_TEST;
					start_d = 1'b1; // R1
				end
			end
			CSTG_ZERO:
			begin
				if (i_zero_done)
				begin
					state_d = CSTG_TEST;
					start_d = 1'b1; // R1
				end
			end
			CSTG_TEST:
			begin
				if (i_crc_done)
				begin
					seen_d[`CSTG_F_CRC] = 1'b1;
					if (i_crc_calc != i_crc_ref)
						fail_d[`CSTG_F_CRC] = 1'b1; // R5 R16
				end
				// Each AES direction and mode is tracked on its own.
				aes_seen_d = aes_seen_q | {i_ofb_dec_done, i_ofb_enc_done, i_ecb_dec_done, i_ecb_enc_done};
				aes_fail_d = aes_fail_q | {kat_bad(i_ofb_dec_done, i_ofb_dec_pass),
					kat_bad(i_ofb_enc_done, i_ofb_enc_pass),
					kat_bad(i_ecb_dec_done, i_ecb_dec_pass),
					kat_bad(i_ecb_enc_done, i_ecb_enc_pass)}; // R6
				seen_d[`CSTG_F_ECB] = &aes_seen_d[1:0];
				seen_d[`CSTG_F_OFB] = &aes_seen_d[3:2];
				fail_d[`CSTG_F_ECB] = |aes_fail_d[1:0]; // R16
				fail_d[`CSTG_F_OFB] = |aes_fail_d[3:2]; // R16
				if (i_cmac_done)
				begin
					seen_d[`CSTG_F_CMAC] = 1'b1;
					fail_d[`CSTG_F_CMAC] = fail_q[`CSTG_F_CMAC] | ~i_cmac_pass; // R7
				end
				if (i_sha_done)
				begin
					seen_d[`CSTG_F_SHA] = 1'b1;
					fail_d[`CSTG_F_SHA] = fail_q[`CSTG_F_SHA] | ~i_sha_pass; // R7
				end
				if (&seen_d)
					state_d = (|fail_d) ? CSTG_ERR : CSTG_RUN; // R2 R3
			end
			CSTG_RUN:
			begin
				if (i_active_tamper || i_radio_id_mismatch)
					state_d = CSTG_RUN;
			end
			CSTG_ERR:
			begin
				state_d = CSTG_ERR; // R17
			end
			default:
			begin
				state_d = CSTG_ERR;
			end
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_q <= CSTG_BOOT;
			fail_q <= `CSTG_FAIL_RST;
			seen_q <= `CSTG_FAIL_RST;
			start_q <= 1'b0;
			aes_seen_q <= 4'h0;
			aes_fail_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			fail_q <= fail_d;
			seen_q <= seen_d;
			start_q <= start_d;
			aes_seen_q <= aes_seen_d;
			aes_fail_q <= aes_fail_d;
		end
	end

	// ----------------------------------------
	// Zeroization, firmware and random checks
	// ----------------------------------------
	logic [`CSTG_RND_W-1:0] last_rnd_q, last_rnd_d;
	logic have_rnd_q, have_rnd_d;
	logic rnd_ok;
	logic boot_zero;

	// Boot erasure is requested from the tamper decision until the key store reports it is done.
	// Holding it through the zeroize state keeps the request standing however long the erase takes.
	assign boot_zero = ((state_q == CSTG_BOOT) && i_static_tamper) || (state_q == CSTG_ZERO); // R11
	assign rnd_ok = i_rnd_valid && !(have_rnd_q && (i_rnd_value == last_rnd_q)); // R9

	always_comb
	begin
		last_rnd_d = last_rnd_q;
		have_rnd_d = have_rnd_q;
		if (i_rnd_valid)
		begin
			last_rnd_d = i_rnd_value;
			have_rnd_d = 1'b1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			last_rnd_q <= {`CSTG_RND_W{1'b0}};
			have_rnd_q <= 1'b0;
			o_rnd_value <= {`CSTG_RND_W{1'b0}};
		end
		else
		begin
			last_rnd_q <= last_rnd_d;
			have_rnd_q <= have_rnd_d;
			// Only draws released in normal operation leave the block; anything else reads as zero.
			o_rnd_value <= o_rnd_valid ? i_rnd_value : {`CSTG_RND_W{1'b0}}; // R9 R12
		end
	end

	logic in_run;
	logic tamper_now;
	assign in_run = (state_q == CSTG_RUN);
	assign tamper_now = i_active_tamper && (state_q != CSTG_BOOT);

	assign o_rnd_valid = in_run && rnd_ok;
	assign o_rnd_reject = i_rnd_valid && !(in_run && rnd_ok); // R9 R12
	assign o_zero_traffic_keys = tamper_now | boot_zero | i_radio_id_mismatch; // R10 R11 R14
	assign o_zero_integrity_keys = tamper_now | boot_zero; // R10 R11
	assign o_zero_rekey_keys = i_radio_id_mismatch | (tamper_now & i_key_retention); // R14 R15
	assign o_zero_ram_keys = tamper_now | boot_zero; // R15
	assign o_fw_accept = i_fw_load_done && i_fw_cmac_pass && in_run; // R8
	assign o_fw_reject = i_fw_load_done && !(i_fw_cmac_pass && in_run); // R8

	// ----------------------------------------
	// Service gating and status
	// ----------------------------------------
	assign o_selftest_start = start_q;
	assign o_error = (state_q == CSTG_ERR);
	assign o_crypto_enable = in_run; // R2 R12
	assign o_data_out_enable = in_run && !tamper_now && !i_radio_id_mismatch; // R12
	assign o_req_accept = i_req_valid && (in_run || (o_error && i_req_is_status)); // R4
	assign o_req_reject = i_req_valid && !o_req_accept; // R4
	// Status only ever carries the code and failure vector, never key material.
	assign o_status_code = o_error ? `CSTG_ERR_CODE : `CSTG_OK_CODE; // R3 R13
	assign o_fail_vector = fail_q; // R13 R16

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_start_after_rst: assert property (@(posedge i_clock) // R1
		$fell(i_rst) && !i_static_tamper |=> o_selftest_start)
		else $error("self-test not started after reset");
	a_no_crypto_early: assert property (@(posedge i_clock) disable iff (i_rst) // R2
		(state_q == CSTG_TEST) |-> !o_crypto_enable)
		else $error("crypto enabled during self-test");
	a_err_code: assert property (@(posedge i_clock) disable iff (i_rst) // R3
		o_error |-> (o_status_code == 16'hAA01) && (|o_fail_vector))
		else $error("error state without code or failure bits");
	a_err_only_status: assert property (@(posedge i_clock) disable iff (i_rst) // R4
		o_error && i_req_valid && !i_req_is_status |-> o_req_reject)
		else $error("non-status request accepted in error");
	a_crc_fail: assert property (@(posedge i_clock) disable iff (i_rst) // R5
		(state_q == CSTG_TEST) && i_crc_done && (i_crc_calc != i_crc_ref) |=> o_fail_vector[`CSTG_F_CRC])
		else $error("crc mismatch not recorded");
	a_fw_gate: assert property (@(posedge i_clock) disable iff (i_rst) // R8
		o_fw_accept |-> i_fw_cmac_pass)
		else $error("firmware accepted without cmac pass");
	a_rnd_repeat: assert property (@(posedge i_clock) disable iff (i_rst) // R9
		i_rnd_valid && have_rnd_q && (i_rnd_value == last_rnd_q) |-> o_rnd_reject && !o_rnd_valid)
		else $error("repeated random value passed");
	a_tamper_zero: assert property (@(posedge i_clock) disable iff (i_rst) // R10
		i_active_tamper && (state_q != CSTG_BOOT) |-> o_zero_traffic_keys && o_zero_integrity_keys)
		else $error("tamper did not zeroize");
	a_retention: assert property (@(posedge i_clock) disable iff (i_rst) // R15
		tamper_now && !i_key_retention && !i_radio_id_mismatch |-> !o_zero_rekey_keys && o_zero_ram_keys)
		else $error("retention flag ignored");
	a_err_sticky: assert property (@(posedge i_clock) disable iff (i_rst) // R17
		o_error |=> o_error [*8])
		else $error("error state left without reset");
	a_boot_zero: assert property (@(posedge i_clock) disable iff (i_rst) // R11
		(state_q == CSTG_ZERO) |-> o_zero_traffic_keys && o_zero_integrity_keys && !o_data_out_enable)
		else $error("boot erasure not requested");
	a_id_zero: assert property (@(posedge i_clock) disable iff (i_rst) // R14
		i_radio_id_mismatch |-> o_zero_traffic_keys && o_zero_rekey_keys && !o_data_out_enable)
		else $error("radio mismatch did not zeroize");
	a_quiet_not_run: assert property (@(posedge i_clock) disable iff (i_rst) // R12
		(state_q != CSTG_RUN) |-> !o_data_out_enable && !o_rnd_valid && !o_fw_accept)
		else $error("output released outside normal operation");
	a_rnd_value_gate: assert property (@(posedge i_clock) disable iff (i_rst) // R12
		!o_rnd_valid |=> (o_rnd_value == {`CSTG_RND_W{1'b0}}))
		else $error("random value leaked without release");
	a_fail_bits_set: assert property (@(posedge i_clock) disable iff (i_rst) // R16
		1'b1 |=> ((o_fail_vector & $past(o_fail_vector)) == $past(o_fail_vector)))
		else $error("failure bit cleared without reset");
	c_pass: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_crypto_enable));
	c_fail: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_error));
	c_boot_zero: cover property (@(posedge i_clock) boot_zero);
	c_rnd_rej: cover property (@(posedge i_clock) disable iff (i_rst) o_rnd_reject && in_run);
	c_tamper_run: cover property (@(posedge i_clock) disable iff (i_rst) tamper_now && in_run);
endmodule : cstg_guard

// *** cstg_host_model.sv ***
`timescale 1ns/1ps
module cstg_host_model
(
	input wire logic i_clock,
	input wire logic i_start,
	input wire logic [4:0] i_fail,
	output logic [6:0] o_done,
	output logic [6:0] o_pass,
	output logic [15:0] o_crc_calc,
	output logic [15:0] o_crc_ref
);
	logic [6:0] good;
	assign good = ~{i_fail[4], i_fail[3], {2{i_fail[2]}}, {2{i_fail[1]}}, i_fail[0]};
	initial
	begin
		o_done = 7'h00;
		o_pass = 7'h00;
		o_crc_ref = 16'h5A3C;
		o_crc_calc = 16'hA5C3;
		forever
		begin
			@(posedge i_clock iff i_start);
			// Each test reports once; pass lines mean nothing outside a done pulse, so they toggle there.
			for (int k = 0; k < 7; k++)
			begin
				@(negedge i_clock);
				o_done = 7'h01 << k;
				o_pass = good;
				o_crc_calc = i_fail[0] ? ~o_crc_ref : o_crc_ref;
			end
			@(negedge i_clock);
			o_done = 7'h00;
			o_pass = ~o_pass;
			o_crc_calc = ~o_crc_calc;
		end
	end
endmodule : cstg_host_model

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "cstg_cfg.svh"
module tb_top;
	import cstg_pkg::*;
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
	logic i_clock = 0, i_rst = 1, st = 0, at = 0, idm = 0, kr = 0, fwd = 0, fwp = 0, rv = 0, qv = 0, qs = 0, zd = 0;
	logic [31:0] rval = 32'h78948234;
	logic [4:0] fmask = 5'h00;
	logic [6:0] dn, ps;
	logic [15:0] cc, cr, sc;
	logic sst, cen, den, qa, qr, err, zt, zi, zr, zm, fa, fr, rov, rrj;
	cstg_fail_t fv;
	logic [1:0] expq[$];
	logic [1:0] exp_resp;
	logic [31:0] rvo;
	int fail_count = 0, num_checks = 0, cyc = 0, n;
	always #5 i_clock = ~i_clock;
	cstg_host_model u_host (.i_clock(i_clock), .i_start(sst), .i_fail(fmask), .o_done(dn), .o_pass(ps),
		.o_crc_calc(cc), .o_crc_ref(cr));
	cstg_guard dut (.i_clock(i_clock), .i_rst(i_rst), .i_static_tamper(st), .i_active_tamper(at),
		.i_radio_id_mismatch(idm), .i_key_retention(kr), .i_crc_calc(cc), .i_crc_ref(cr), .i_crc_done(dn[0]),
		.i_ecb_enc_done(dn[1]), .i_ecb_enc_pass(ps[1]), .i_ecb_dec_done(dn[2]), .i_ecb_dec_pass(ps[2]),
		.i_ofb_enc_done(dn[3]), .i_ofb_enc_pass(ps[3]), .i_ofb_dec_done(dn[4]), .i_ofb_dec_pass(ps[4]),
		.i_cmac_done(dn[5]), .i_cmac_pass(ps[5]), .i_sha_done(dn[6]), .i_sha_pass(ps[6]),
		.i_fw_load_done(fwd), .i_fw_cmac_pass(fwp), .i_rnd_valid(rv), .i_rnd_value(rval), .i_req_valid(qv),
		.i_req_is_status(qs), .i_zero_done(zd), .o_selftest_start(sst), .o_crypto_enable(cen),
		.o_data_out_enable(den), .o_req_accept(qa), .o_req_reject(qr), .o_status_code(sc), .o_fail_vector(fv),
		.o_error(err), .o_zero_traffic_keys(zt), .o_zero_integrity_keys(zi), .o_zero_rekey_keys(zr),
		.o_zero_ram_keys(zm), .o_fw_accept(fa), .o_fw_reject(fr), .o_rnd_valid(rov), .o_rnd_value(rvo),
		.o_rnd_reject(rrj));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	// Kind 0 is a service request, 1 a firmware load, 2 a random draw; e is {accepted, rejected}.
	task automatic op(input int k, input logic b, input logic [1:0] e);
		@(negedge i_clock);
		expq.push_back(e);
		qv = (k == 0);
		fwd = (k == 1);
		rv = (k == 2);
		qs = b;
		fwp = b;
		@(negedge i_clock);
		{qv, fwd, rv} = 3'h0;
		if (k == 2)
			`CHK("rnd_value", e[1] ? rval : 32'h0, rvo)
	endtask : op
	task automatic boot(input logic s, input logic [4:0] f);
		fmask = f;
		st = s;
		i_rst = 1;
		repeat (20) @(negedge i_clock);
		i_rst = 0;
		if (s)
		begin
			repeat (2) @(negedge i_clock);
			`CHK("zero_traffic", 1'b1, zt)
			`CHK("zero_integrity", 1'b1, zi)
			zd = 1;
			@(negedge i_clock);
			zd = 0;
			st = 0;
		end
		n = 0;
		while (sst !== 1'b1 && n < 50)
		begin
			@(negedge i_clock);
			n++;
		end
		`CHK("start", 1'b1, sst)
		op(0, 1'b0, 2'b01);
		`CHK("data_out", 1'b0, den)
		n = 0;
		while (cen !== 1'b1 && err !== 1'b1 && n < 50)
		begin
			@(negedge i_clock);
			n++;
		end
	endtask : boot
	// ----------------------------------------
	// Watcher and timeout
	// ----------------------------------------
	always
	begin
		@(negedge i_clock);
		#4;
		if ((qv || fwd || rv) && expq.size() > 0)
		begin
			exp_resp = expq.pop_front();
			`CHK("response", exp_resp, qv ? {qa, qr} : fwd ? {fa, fr} : {rov, rrj})
		end
	end
	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	initial
	begin
		boot(1'b0, 5'h00);
		`CHK("crypto_on", 1'b1, cen)
		`CHK("fail_vec", 5'h00, fv)
		`CHK("status", `CSTG_OK_CODE, sc)
		op(0, 1'b0, 2'b10);
		op(1, 1'b1, 2'b10);
		op(1, 1'b0, 2'b01);
		for (int i = 0; i < 4; i++)
		begin
			rval = xs(rval);
			op(2, 1'b0, 2'b10);
		end
		op(2, 1'b0, 2'b01);
		for (int i = 0; i < 2; i++)
		begin
			@(negedge i_clock);
			kr = i[0];
			at = 1;
			#1;
			`CHK("zero_traffic", 1'b1, zt)
			`CHK("zero_integrity", 1'b1, zi)
			`CHK("zero_scope", 1'b1, kr ? zr : zm)
			`CHK("zero_rekey", kr, zr)
			`CHK("data_out", 1'b0, den)
			@(negedge i_clock);
			at = 0;
		end
		@(negedge i_clock);
		idm = 1;
		#1;
		`CHK("id_traffic", 1'b1, zt)
		`CHK("id_rekey", 1'b1, zr)
		@(negedge i_clock);
		idm = 0;
		$display("test normal boot done");
		for (int i = 0; i < 6; i++)
		begin
			boot(1'b0, i < 5 ? 5'h01 << i : 5'h1F);
			`CHK("error", 1'b1, err)
			`CHK("status", `CSTG_ERR_CODE, sc)
			`CHK("fail_vec", i < 5 ? 5'h01 << i : 5'h1F, fv)
			`CHK("crypto_on", 1'b0, cen)
			op(0, 1'b1, 2'b10);
			op(0, 1'b0, 2'b01);
			op(2, 1'b0, 2'b01);
			`CHK("error_held", 1'b1, err)
			`CHK("data_out", 1'b0, den)
			$display("test failing boot %0d done", i);
		end
		boot(1'b1, 5'h00);
		`CHK("crypto_on", 1'b1, cen)
		$display("test tamper boot done");
		print_verdict();
	end
endmodule : tb_top
